// >>> hdl/sdp_dev.sv
// device end: shifts in words, holds divider words, runs calibration
// assumes link wires are synchronous to ref_clk_in and held >= 1 cycle
`timescale 1ns/10ps
module sdp_dev
   import sdp_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = CAL_CYC
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   sdp_link_if.dev          link,
   output logic [6:0]       whole_ratio_bits_out,
   output logic             ratio_kind_select_out,
   output logic [10:0]      denominator_value_out,
   output logic [10:0]      numerator_bits_out,
   output logic             frac_mode_out,
   output logic [10:0]      eff_numerator_out,
   output logic             ratio_ok_out,
   output logic             frac_ok_out,
   output logic             synth_power_on_out,
   output logic             bias_init_out,
   output logic             cal_busy_out,
   output logic             cal_final_out,
   output logic             short_frame_out
);
   // ==========================================================
   // state
   typedef struct packed {
      logic              sclk_q;
      logic              le_q;
      logic [WORD_W-1:0] shreg;
      logic [4:0]        cnt;
      logic [6:0]        ratio;
      logic              kind;
      logic [10:0]       den;
      logic [10:0]       num;
      logic              frac_mode;
      logic [10:0]       eff_num;
      logic              ratio_ok;
      logic              frac_ok;
      logic              pwr;
      logic              bias_init;
      logic [TMR_W-1:0]  cal_cnt;
      logic              cal_busy;
      logic              cal_final;
      logic              short_frame;
   } sdp_dev_state_type;

   sdp_dev_state_type st_ff;
   sdp_dev_state_type nxt_st;

   localparam sdp_dev_state_type ST_RST = '{
      sclk_q: 1'b0, le_q: 1'b0, shreg: '0, cnt: 5'h00,
      ratio: RST_RATIO, kind: 1'b0, den: RST_DEN, num: RST_NUM,
      frac_mode: 1'b1, eff_num: RST_NUM, ratio_ok: 1'b0, frac_ok: 1'b1,
      pwr: 1'b0, bias_init: 1'b0, cal_cnt: '0, cal_busy: 1'b0,
      cal_final: 1'b0, short_frame: 1'b0};

   logic              sclk_rise;
   logic              frame_end;
   logic [2:0]        sel;
   logic              start_cal;

   // ==========================================================
   // next state
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.bias_init = 1'b0;
      nxt_st.sclk_q    = link.sclk;
      nxt_st.le_q      = link.le;
      sclk_rise        = link.sclk & ~st_ff.sclk_q;
      frame_end        = link.le & ~st_ff.le_q;
      sel              = st_ff.shreg[SEL_LSB +: 3];
      start_cal        = 1'b0;

      // bits enter msb first on rising clock while latch is low
      if (sclk_rise && !link.le) begin
         nxt_st.shreg = {st_ff.shreg[WORD_W-2:0], link.sdata}; // RL12
         if (st_ff.cnt != 5'h1F) begin
            nxt_st.cnt = st_ff.cnt + 5'h01;
         end
      end

      if (frame_end) begin
         nxt_st.cnt = 5'h00;
         // a short or long frame is dropped so a glitch cannot retune
         if (st_ff.cnt == WORD_BITS) begin // RL15
            nxt_st.short_frame = 1'b0;
            case (sel) // RL12
               W_RATIO: begin
                  nxt_st.ratio = st_ff.shreg[RATIO_LSB +: 7]; // RL6
                  nxt_st.kind  = st_ff.shreg[KIND_BIT]; // RL6
                  start_cal    = 1'b1;
               end
               W_DEN: begin
                  nxt_st.den = st_ff.shreg[FRAC_LSB +: 11]; // RL10
                  start_cal  = 1'b1;
               end
               W_NUM: begin
                  nxt_st.num = st_ff.shreg[FRAC_LSB +: 11]; // RL11
                  start_cal  = 1'b1;
               end
               W_LOMIX: begin
                  nxt_st.pwr = st_ff.shreg[PWR_BIT];
                  // off-on edge restarts bias setup from a clean state
                  if (st_ff.shreg[PWR_BIT] && !st_ff.pwr) begin
                     nxt_st.bias_init = 1'b1; // RL2
                  end
               end
               default: begin
               end
            endcase
         end else begin
            nxt_st.short_frame = 1'b1; // RL15
         end
      end

      // calibration: any ratio word restarts it while synth power is on; word 0 marks the final pass
      if (start_cal && nxt_st.pwr) begin
         nxt_st.cal_cnt   = CAL_CYCLES[TMR_W-1:0]; // RL5 RL13
         nxt_st.cal_final = (sel == W_RATIO); // RL5
      end else if (!nxt_st.pwr || nxt_st.bias_init) begin
         nxt_st.cal_cnt   = '0; // RL2
         nxt_st.cal_final = 1'b0;
      end else if (st_ff.cal_cnt != '0) begin
         nxt_st.cal_cnt = st_ff.cal_cnt - 1'b1;
      end
      nxt_st.cal_busy = (nxt_st.cal_cnt != '0);

      // divider view of the held words
      nxt_st.frac_mode = ~nxt_st.kind; // RL7
      nxt_st.eff_num   = nxt_st.kind ? 11'h000 : nxt_st.num; // RL7
      if (nxt_st.kind) begin
         nxt_st.ratio_ok = (nxt_st.ratio >= WHOLE_MIN) && (nxt_st.ratio <= WHOLE_MAX); // RL9
         nxt_st.frac_ok  = 1'b1; // RL7
      end else begin
         nxt_st.ratio_ok = (nxt_st.ratio >= FRAC_MIN) && (nxt_st.ratio <= FRAC_MAX); // RL8
         nxt_st.frac_ok  = (nxt_st.den != 11'h000) && (nxt_st.num < nxt_st.den); // RL8 RL11
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign whole_ratio_bits_out  = st_ff.ratio;
   assign ratio_kind_select_out = st_ff.kind;
   assign denominator_value_out = st_ff.den;
   assign numerator_bits_out    = st_ff.num;
   assign frac_mode_out         = st_ff.frac_mode;
   assign eff_numerator_out     = st_ff.eff_num;
   assign ratio_ok_out          = st_ff.ratio_ok;
   assign frac_ok_out           = st_ff.frac_ok;
   assign synth_power_on_out    = st_ff.pwr;
   assign bias_init_out         = st_ff.bias_init;
   assign cal_busy_out          = st_ff.cal_busy;
   assign cal_final_out         = st_ff.cal_final;
   assign short_frame_out       = st_ff.short_frame;
endmodule

// >>> hdl/sdp_host.sv
// host end: AHB-Lite slave registers feeding a serial word sender
// assumes a single AHB master, word transfers, and the link interface
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module sdp_host
   import sdp_pkg::*;
#(
   parameter int unsigned PWR_WAIT_CYCLES = PWR_WAIT_CYC,
   parameter int unsigned INT_WAIT_CYCLES = INT_WAIT_CYC
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic [31:0]      hrdata_out,
   sdp_link_if.host         link
);
   // ==========================================================
   // state
   typedef struct packed {
      logic              wr_pend;
      logic [7:0]        wr_addr;
      logic [31:0]       hrdata;
      logic [WORD_W-1:0] word;
      logic              have_word;
      logic [7:0]        div;
      logic [7:0]        tcnt;
      sdp_host_fsm_type  fsm;
      logic [4:0]        bits;
      logic [WORD_W-1:0] shreg;
      logic              sclk;
      logic              sdata;
      logic              le;
      logic [TMR_W-1:0]  pwr_tmr;
      logic [TMR_W-1:0]  int_tmr;
      logic              pwr_off;
      logic              int_pend;
   } sdp_host_state_type;

   sdp_host_state_type st_ff;
   sdp_host_state_type nxt_st;
   logic               take;
   logic               tick;
   logic               hold;
   logic [2:0]         sel;

   // ==========================================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      take   = hsel_in & htrans_in[1] & hready_in;
      tick   = (st_ff.tcnt == 8'h00);
      sel    = st_ff.word[SEL_LSB +: 3];
      hold   = 1'b0;
      nxt_st.tcnt = tick ? st_ff.div : st_ff.tcnt - 8'h01;
      if (st_ff.pwr_tmr != '1) begin
         nxt_st.pwr_tmr = st_ff.pwr_tmr + 1'b1;
      end
      if (st_ff.int_tmr != '1) begin
         nxt_st.int_tmr = st_ff.int_tmr + 1'b1;
      end

      // bus: read data is ready in the cycle after the address phase
      nxt_st.wr_pend = take & hwrite_in;
      nxt_st.wr_addr = haddr_in[7:0];
      nxt_st.hrdata  = 32'h00000000;
      if (take && !hwrite_in) begin
         case (haddr_in[7:0])
            ADDR_DATA: nxt_st.hrdata = {8'h00, st_ff.word};
            ADDR_STAT: nxt_st.hrdata = {30'h0, st_ff.fsm == H_GAP, st_ff.have_word};
            ADDR_DIV:  nxt_st.hrdata = {24'h000000, st_ff.div};
            default:   nxt_st.hrdata = 32'h00000000;
         endcase
      end
      // a word written while one is in flight is dropped; poll busy first
      if (st_ff.wr_pend) begin
         if (st_ff.wr_addr == ADDR_DATA && !st_ff.have_word) begin
            nxt_st.word      = hwdata_in[WORD_W-1:0];
            nxt_st.have_word = 1'b1;
            if (hwdata_in[2:0] == W_RATIO) begin
               nxt_st.word = hwdata_in[WORD_W-1:0] & KEEP_RATIO; // RL14
            end else if (hwdata_in[2:0] == W_DEN || hwdata_in[2:0] == W_NUM) begin
               nxt_st.word = hwdata_in[WORD_W-1:0] & KEEP_FRAC; // RL14
            end
         end else if (st_ff.wr_addr == ADDR_DIV) begin
            nxt_st.div = hwdata_in[7:0];
         end
      end

      case (st_ff.fsm)
         H_IDLE: begin
            if (st_ff.have_word) begin
               nxt_st.fsm = H_GAP;
            end
         end
         H_GAP: begin
            if (sel == W_LOMIX && st_ff.word[PWR_BIT] && st_ff.pwr_off &&
                st_ff.pwr_tmr < PWR_WAIT_CYCLES[TMR_W-1:0]) begin
               hold = 1'b1; // RL1
            end
            if (sel == W_RATIO && st_ff.int_pend &&
                st_ff.int_tmr < INT_WAIT_CYCLES[TMR_W-1:0]) begin
               hold = 1'b1; // RL3 RL4
            end
            if (!hold && tick) begin
               nxt_st.fsm   = H_SHIFT;
               nxt_st.bits  = 5'h00;
               nxt_st.shreg = {st_ff.word[WORD_W-2:0], 1'b0};
               nxt_st.sdata = st_ff.word[WORD_W-1]; // RL12
            end
         end
         H_SHIFT: begin
            if (tick) begin
               nxt_st.sclk = ~st_ff.sclk;
               if (st_ff.sclk) begin
                  if (st_ff.bits == WORD_BITS - 5'h01) begin
                     nxt_st.fsm = H_LATCH;
                  end else begin
                     nxt_st.bits  = st_ff.bits + 5'h01;
                     nxt_st.sdata = st_ff.shreg[WORD_W-1];
                     nxt_st.shreg = {st_ff.shreg[WORD_W-2:0], 1'b0};
                  end
               end
            end
         end
         H_LATCH: begin
            if (tick) begin
               nxt_st.le = ~st_ff.le;
               if (st_ff.le) begin
                  nxt_st.fsm       = H_IDLE;
                  nxt_st.have_word = 1'b0;
                  if (sel == W_LOMIX) begin
                     nxt_st.pwr_off = ~st_ff.word[PWR_BIT]; // RL1
                     nxt_st.pwr_tmr = '0;
                  end
                  if (sel == W_DEN || sel == W_NUM) begin
                     nxt_st.int_pend = 1'b1; // RL4
                     nxt_st.int_tmr  = '0;
                  end
                  if (sel == W_RATIO) begin
                     nxt_st.int_pend = 1'b0;
                  end
               end
            end
         end
         default: nxt_st.fsm = H_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff         <= '0;
         st_ff.div     <= RST_DIV;
         st_ff.fsm     <= H_IDLE;
         hreadyout_out <= 1'b0;
      end else begin
         st_ff         <= nxt_st;
         hreadyout_out <= 1'b1;
      end
   end

   assign hresp_out  = 1'b0;
   assign hrdata_out = st_ff.hrdata;
   assign link.sclk  = st_ff.sclk;
   assign link.sdata = st_ff.sdata;
   assign link.le    = st_ff.le;
endmodule

// >>> hdl/sdp_link_if.sv
// three-wire programming link between host and device
// assumes the host drives every wire; nothing is bidirectional
`timescale 1ns/10ps
interface sdp_link_if;
   logic sclk;
   logic sdata;
   logic le;
   modport host (output sclk, output sdata, output le);
   modport dev  (input sclk, input sdata, input le);
endinterface

// >>> hdl/sdp_pkg.sv
// constants shared by both ends of the divider programming link
// assumes one 25 MHz clock on each end and a three-wire word link
//
// Summary of operation
// [RL1] host resets synth: power bit off, >100ms, on
// [RL2] power bit off-on reinitialises device bias state
// [RL3] init order 7,6,4,3,2,1, >1ms, then 0
// [RL4] retune: >500us before final whole ratio word
// [RL5] ratio words start calibration, final waits earlier
// [RL6] word 000 loads ratio bits 9:3, kind bit 10
// [RL7] kind 0 fractional, kind 1 whole ratio only
// [RL8] fractional ratio legal from 24 to 119
// [RL9] whole ratio legal from 21 to 123
// [RL10] word 001 loads 11-bit denominator, bits 13:3
// [RL11] word 010 loads numerator, below denominator
// [RL12] 24-bit words, low three bits select word
// [RL13] calibration runs on words 0, 1, 2
// [RL14] host zeroes reserved bits of words 0-2
// [RL15] only complete 24-bit transfers load a word
package sdp_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_KHZ     = 25000;
   localparam int unsigned PWR_WAIT_MS = 100;
   localparam int unsigned PWR_WAIT_CYC = PWR_WAIT_MS * CLK_KHZ + 1;
   // 1 ms gap covers both the init and the retune minimum
   localparam int unsigned INT_WAIT_US = 1000;
   localparam int unsigned INT_WAIT_CYC = (INT_WAIT_US * CLK_KHZ + 999) / 1000 + 1;
   localparam int unsigned CAL_TIME_US = 400;
   localparam int unsigned CAL_CYC     = (CAL_TIME_US * CLK_KHZ) / 1000;
   localparam int          TMR_W       = 22;
   // ==========================================================
   // word layout
   localparam int          WORD_W    = 24;
   localparam logic [4:0]  WORD_BITS = 5'h18;
   localparam int          SEL_LSB   = 0;
   localparam int          RATIO_LSB = 3;
   localparam int          KIND_BIT  = 10;
   localparam int          FRAC_LSB  = 3;
   localparam int          PWR_BIT   = 6;
   localparam logic [2:0]  W_RATIO   = 3'h0;
   localparam logic [2:0]  W_DEN     = 3'h1;
   localparam logic [2:0]  W_NUM     = 3'h2;
   localparam logic [2:0]  W_LOMIX   = 3'h5;
   localparam logic [WORD_W-1:0] KEEP_RATIO = 24'h0007FF;
   localparam logic [WORD_W-1:0] KEEP_FRAC  = 24'h003FFF;
   // ==========================================================
   // ratio limits and reset values
   localparam logic [6:0]  FRAC_MIN  = 7'h18;
   localparam logic [6:0]  FRAC_MAX  = 7'h77;
   localparam logic [6:0]  WHOLE_MIN = 7'h15;
   localparam logic [6:0]  WHOLE_MAX = 7'h7B;
   localparam logic [6:0]  RST_RATIO = 7'h00;
   localparam logic [10:0] RST_DEN   = 11'h001;
   localparam logic [10:0] RST_NUM   = 11'h000;
   // ==========================================================
   // host register map
   localparam logic [7:0]  ADDR_DATA = 8'h00;
   localparam logic [7:0]  ADDR_STAT = 8'h04;
   localparam logic [7:0]  ADDR_DIV  = 8'h08;
   localparam logic [7:0]  RST_DIV   = 8'h04;

   typedef enum logic [1:0] {H_IDLE, H_GAP, H_SHIFT, H_LATCH} sdp_host_fsm_type;
endpackage

// >>> testbench/sdp_checker.sv
// concurrent checks on the programming link and device outputs
// assumes instantiation beside the link; host DIV stays at reset value
`timescale 1ns/10ps
module sdp_checker
   import sdp_pkg::*;
#(
   parameter int CAL_CYCLES = 20
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        sclk,
   input  wire logic        sdata,
   input  wire logic        le,
   input  wire logic [6:0]  whole_ratio_bits_out,
   input  wire logic        ratio_kind_select_out,
   input  wire logic [10:0] denominator_value_out,
   input  wire logic [10:0] numerator_bits_out,
   input  wire logic        frac_mode_out,
   input  wire logic [10:0] eff_numerator_out,
   input  wire logic        ratio_ok_out,
   input  wire logic        frac_ok_out,
   input  wire logic        bias_init_out,
   input  wire logic        cal_busy_out
);
   // ==========================================================
   // helper counters
   logic [4:0]  bits_ff;
   logic        sclk_ff;
   logic [15:0] busy_ff;
   logic [6:0]  r;
   logic        k;
   assign r = whole_ratio_bits_out;
   assign k = ratio_kind_select_out;
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bits_ff <= 5'h00;
         sclk_ff <= 1'b0;
         busy_ff <= 16'h0000;
      end else begin
         sclk_ff <= sclk;
         busy_ff <= cal_busy_out ? busy_ff + 16'h0001 : 16'h0000;
         if (le) begin
            bits_ff <= 5'h00;
         end else if (sclk && !sclk_ff) begin
            bits_ff <= bits_ff + 5'h01;
         end
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   a_latch_clock_low: assert property (le |-> !sclk)
      else $error("shift clock high while latching");
   a_data_hold: assert property (sclk && sclk_ff |-> $stable(sdata))
      else $error("data moved while shift clock high");
   a_frame_bits: assert property ($rose(le) |-> bits_ff == 5'h18)
      else $error("frame closed with wrong bit count");
   a_latch_width: assert property ($rose(le) |-> le [*5] ##1 !le)
      else $error("latch pulse has wrong width");
   a_mode_follow: assert property ($stable(k) |-> frac_mode_out != k)
      else $error("mode output disagrees with kind bit");
   a_eff_numer: assert property ($stable(k) && $stable(numerator_bits_out)
      |-> eff_numerator_out == (k ? 11'h000 : numerator_bits_out))
      else $error("effective numerator wrong");
   a_ratio_range: assert property ($stable(r) && $stable(k) |-> ratio_ok_out ==
      (k ? (r >= WHOLE_MIN && r <= WHOLE_MAX) : (r >= FRAC_MIN && r <= FRAC_MAX)))
      else $error("ratio range flag wrong");
   a_fraction_ok: assert property ($stable(k) && $stable(denominator_value_out)
      && $stable(numerator_bits_out) |-> frac_ok_out == (k ||
      (denominator_value_out != 11'h000 && numerator_bits_out < denominator_value_out)))
      else $error("fraction flag wrong");
   a_bias_pulse: assert property (bias_init_out |=> !bias_init_out)
      else $error("bias init longer than one cycle");
   a_cal_length: assert property ($fell(cal_busy_out) |-> busy_ff == CAL_CYCLES)
      else $error("calibration length wrong");
endmodule

// >>> testbench/tb_top.sv
// bench: host and device joined by the link, plus a bench-driven link
// assumes sdp_pkg constants and the host's zero-wait AHB-Lite slave
`timescale 1ns/10ps
module tb_top;
   import sdp_pkg::*;
   typedef struct packed {
      logic [23:0] word;
      logic        ok;
   } sdp_row_type;
   logic        ref_clk_in, rstn_in, hsel, hwrite, hready, hresp;
   logic [2:0]  hsize;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [6:0]  ratio, m_ratio;
   logic        kind, m_kind, fmode, rok, fok, pwr, bias, cbusy, cfin, short2;
   logic [10:0] den, num, effn, den2, m_den, m_num;
   int          fails, comparisons, starts, pulses;
   int          cyc = 0;
   sdp_row_type rows [13];
   logic [2:0]  order [4] = '{3'h7, 3'h6, 3'h4, 3'h3};
   sdp_link_if link ();
   sdp_link_if lk2 ();
   sdp_host #(.PWR_WAIT_CYCLES(50), .INT_WAIT_CYCLES(30)) i_sdp_host (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .link(link));
   sdp_dev #(.CAL_CYCLES(20)) i_sdp_dev (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link(link),
      .whole_ratio_bits_out(ratio), .ratio_kind_select_out(kind),
      .denominator_value_out(den), .numerator_bits_out(num), .frac_mode_out(fmode),
      .eff_numerator_out(effn), .ratio_ok_out(rok), .frac_ok_out(fok),
      .synth_power_on_out(pwr), .bias_init_out(bias), .cal_busy_out(cbusy),
      .cal_final_out(cfin), .short_frame_out());
   // second device faces the bench so that faulty frames can be sent
   sdp_dev #(.CAL_CYCLES(20)) i_sdp_dev_b (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link(lk2),
      .whole_ratio_bits_out(), .ratio_kind_select_out(), .denominator_value_out(den2),
      .numerator_bits_out(), .frac_mode_out(), .eff_numerator_out(), .ratio_ok_out(),
      .frac_ok_out(), .synth_power_on_out(), .bias_init_out(), .cal_busy_out(),
      .cal_final_out(), .short_frame_out(short2));
   sdp_checker #(.CAL_CYCLES(20)) i_sdp_checker (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sclk(link.sclk),
      .sdata(link.sdata), .le(link.le), .whole_ratio_bits_out(ratio),
      .ratio_kind_select_out(kind), .denominator_value_out(den),
      .numerator_bits_out(num), .frac_mode_out(fmode), .eff_numerator_out(effn),
      .ratio_ok_out(rok), .frac_ok_out(fok), .bias_init_out(bias), .cal_busy_out(cbusy));
   // ==========================================================
   // clock, timeout, event monitors
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   always @(posedge cbusy) starts++;
   always @(posedge bias) pulses++;
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hsize <= 3'h2;
      hwrite <= wr;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask
   task automatic wait_idle();
      do ahb(1'b0, ADDR_STAT, 32'h0); while (rd[0] !== 1'b0);
      repeat (2) @(posedge ref_clk_in);
   endtask
   task automatic send(input logic [23:0] w);
      ahb(1'b1, ADDR_DATA, {8'h00, w});
      wait_idle();
      if (w[2:0] == W_RATIO) {m_kind, m_ratio} = w[10:3];
      if (w[2:0] == W_DEN) m_den = w[13:3];
      if (w[2:0] == W_NUM) m_num = w[13:3];
   endtask
   // n below 24 makes a deliberately short frame
   task automatic raw(input int n, input logic [23:0] w);
      for (int i = 0; i < n; i++) begin
         lk2.sdata <= w[23-i];
         repeat (5) @(posedge ref_clk_in);
         lk2.sclk <= 1'b1;
         repeat (5) @(posedge ref_clk_in);
         lk2.sclk <= 1'b0;
      end
      lk2.sdata <= ~w[24-n];
      repeat (5) @(posedge ref_clk_in);
      lk2.le <= 1'b1;
      repeat (5) @(posedge ref_clk_in);
      lk2.le <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
   endtask
   task automatic conclude();
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {rstn_in, hsel, haddr, hsize, htrans, hwrite, hwdata} = '0;
      {lk2.sclk, lk2.sdata, lk2.le} = 3'h0;
      {fails, comparisons, starts, pulses} = '0;
      {m_kind, m_ratio, m_den, m_num} = {1'b0, RST_RATIO, RST_DEN, RST_NUM};
      rows = '{'{24'h000001, 1'b0}, '{24'h003FF9, 1'b1}, '{24'h003FF2, 1'b1},
         '{24'h003FFA, 1'b0}, '{24'h000002, 1'b1}, '{24'h0000C0, 1'b1},
         '{24'h0003B8, 1'b1}, '{24'h0003C0, 1'b0}, '{24'h0000B8, 1'b0},
         '{24'h0004A8, 1'b1}, '{24'h0007D8, 1'b1}, '{24'h0007E0, 1'b0},
         '{24'h0004A0, 1'b0}};
      repeat (10) @(posedge ref_clk_in);
      check(hready, 1'b0);
      rstn_in <= 1'b1;
      @(posedge ref_clk_in);
      ahb(1'b0, ADDR_DIV, 32'h0);
      check(rd, RST_DIV);
      ahb(1'b1, ADDR_DIV, 32'h000000A5);
      ahb(1'b0, ADDR_DIV, 32'h0);
      check(rd, 32'h000000A5);
      // back to the reset divider: the latch width check assumes it
      ahb(1'b1, ADDR_DIV, {24'h000000, RST_DIV});
      ahb(1'b0, 8'h0C, 32'h0);
      check(rd, 32'h0);
      check({fmode, fok, pwr, den, num}, {2'h3, 1'b0, RST_DEN, RST_NUM});
      send(24'h000005);
      send(24'h000045);
      check({pwr, pulses[7:0]}, {1'b1, 8'h01});
      for (int k = 0; k < 4; k++) send({21'h0, order[k]});
      check(starts, 0);
      for (int i = 0; i < 13; i++) begin
         send(rows[i].word);
         check(rows[i].word[2:0] == W_RATIO ? rok : fok, rows[i].ok);
         check({ratio, kind}, {m_ratio, m_kind});
         check({den, num}, {m_den, m_num});
         check(starts, i + 1);
         check(cfin, rows[i].word[2:0] == W_RATIO);
      end
      send(24'hFFC012);
      ahb(1'b0, ADDR_DATA, 32'h0);
      check(rd, 32'h00000012);
      send(24'h00002A);
      ahb(1'b1, ADDR_DATA, 32'h000000C0);
      ahb(1'b1, ADDR_DATA, 32'h000003B8);
      ahb(1'b0, ADDR_STAT, 32'h0);
      check(rd[1], 1'b1);
      wait_idle();
      ahb(1'b0, ADDR_DATA, 32'h0);
      check(rd, 32'h000000C0);
      check(ratio, 7'h18);
      raw(23, 24'h003FF9);
      check({short2, den2}, {1'b1, RST_DEN});
      raw(24, 24'h000029);
      check({short2, den2}, {1'b0, 11'h005});
      rstn_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      check({pwr, ratio, den, num}, {1'b0, RST_RATIO, RST_DEN, RST_NUM});
      check(hready, 1'b0);
      rstn_in <= 1'b1;
      @(posedge ref_clk_in);
      ahb(1'b0, ADDR_DIV, 32'h0);
      check(rd, RST_DIV);
      conclude();
   end
endmodule
